/* modulo_timer_top.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: Eight-bit up-counter, free-running or limited by the modulo value.
// RULE2: Overflow interrupt enabled by software gives periodic interrupts.
// RULE3: Prescaler source: bus clock, fixed clock, or count pin rise or fall.
// RULE4: Prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256.
// RULE5: Writing one to counter-clear returns the count to zero.
// RULE6: Halt control freezes the count; counting resumes from it when cleared.
// RULE7: In wait mode counting goes on and the interrupt can wake the core.
// RULE8: Software should halt the timer before wait if not needed for wake.
// RULE9: Stop mode halts the timer always; it never wakes from stop.
// RULE10: Leaving stop through reset puts the timer in its reset state.
// RULE11: Leaving stop through an interrupt keeps state; counting resumes.
// RULE12: Debug halt suspends counting; it resumes from the held value.
// RULE13: Counter-clear or any modulo write resets the timer, beating resume.
// RULE14: Count pin is synchronised to the bus clock before edge use.
// RULE15: Count pin source must stay at or below a quarter of bus clock.
// RULE16: Four eight-bit registers: status, clock config, count, modulo.
// RULE17: Reference clocks are count pin, fixed clock and bus clock.
// RULE18: The fixed clock is the divided reference from the clock generator.
// RULE19: Overflow flag sets on wrap; cleared by read-then-write-zero or reset.
// RULE20: Reset sets halt and clears the interrupt enable.
// RULE21: Source codes 00 bus, 01 fixed, 10 fall, 11 rise; count kept.
// RULE22: Prescale 0000 is divide by one, 1000 and above divide by 256.
// RULE23: Modulo zero lets the counter run through all 256 states.
// RULE24: Interrupt output is high while flag and enable are both set.
module modulo_timer_top
  import modulo_timer_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Avalon-MM slave.
  input wire logic [3:0] address_i,
  input wire logic [3:0] byteenable_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Clock sources and processor modes.
  input wire logic ext_count_pin_i,
  input wire logic divided_ref_clock_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic debug_halt_i,
  // Interrupt request.
  output logic irq_o
);

  // Mask of low prescaler bits that must all be one for a tick.
  function automatic logic [7:0] div_mask(input logic [3:0] ps); // [RULE4]
    logic [3:0] sel;
    sel = (ps > MODULO_TIMER_PS_MAX) ? MODULO_TIMER_PS_MAX : ps; // [RULE22]
    div_mask = ~(8'hFF << sel);
  endfunction

  logic done;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic halt;
  logic ie;
  logic flag;
  logic armed;
  modulo_timer_clkcfg_t cfg;
  logic [7:0] cnt;
  logic [7:0] modv;
  logic [7:0] limit;
  logic [7:0] presc;
  logic ext_s1;
  logic ext_s2;
  logic ext_prev;
  logic ff_s1;
  logic ff_s2;
  logic ff_prev;
  logic src_tick;
  logic run;
  logic tick;
  logic wrap;
  logic wr_status;
  logic wr_clkcfg;
  logic wr_mod;
  logic rd_status;
  logic clr_evt;
  logic flag_swclr;

  // One wait state per access: the request is taken at the second edge.
  assign req = read_i | write_i;
  assign waitrequest_o = req & ~done;
  assign acc_wr = write_i & done;
  assign acc_rd = read_i & done;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done <= 1'b0;
    end else begin
      done <= req & ~done;
    end
  end

  // Write and read decodes, low byte lane only carries data.
  assign wr_status = acc_wr & byteenable_i[0] & (address_i == MODULO_TIMER_OFS_STATUS);
  assign wr_clkcfg = acc_wr & byteenable_i[0] & (address_i == MODULO_TIMER_OFS_CLKCFG);
  assign wr_mod = acc_wr & byteenable_i[0] & (address_i == MODULO_TIMER_OFS_MODULO);
  assign rd_status = acc_rd & (address_i == MODULO_TIMER_OFS_STATUS);

  // Timer reset from counter-clear or any modulo write.
  assign clr_evt = (wr_status & writedata_i[MODULO_TIMER_BIT_CLR]) | wr_mod; // [RULE5] [RULE13]

  // Read data registered in the wait cycle; unmapped reads give zero.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & ~done) begin
      case (address_i)
        MODULO_TIMER_OFS_STATUS: readdata_o <= {24'h0, flag, ie, 1'b0, halt, 4'h0}; // [RULE16]
        MODULO_TIMER_OFS_CLKCFG: readdata_o <= {24'h0, cfg};
        MODULO_TIMER_OFS_COUNT: readdata_o <= {24'h0, cnt};
        MODULO_TIMER_OFS_MODULO: readdata_o <= {24'h0, modv};
        default: readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits of the status register.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt <= MODULO_TIMER_RST_HALT; // [RULE20] [RULE10]
      ie <= MODULO_TIMER_RST_IE;
    end else if (wr_status) begin
      halt <= writedata_i[MODULO_TIMER_BIT_HALT]; // [RULE6]
      ie <= writedata_i[MODULO_TIMER_BIT_IE]; // [RULE2]
    end
  end

  // Clock configuration; changing it never touches the count.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg <= MODULO_TIMER_RST_CLKCFG;
    end else if (wr_clkcfg) begin
      cfg <= modulo_timer_clkcfg_t'({2'b00, writedata_i[5:0]}); // [RULE21]
    end
  end

  // Modulo limit register.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modv <= MODULO_TIMER_RST_MODULO;
    end else if (wr_mod) begin
      modv <= writedata_i[7:0];
    end
  end

  // Two-stage synchronisers for the count pin and the fixed clock.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
      ff_s1 <= 1'b0;
      ff_s2 <= 1'b0;
      ff_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin_i; // [RULE14] [RULE17]
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      ff_s1 <= divided_ref_clock_i; // [RULE18]
      ff_s2 <= ff_s1;
      ff_prev <= ff_s2;
    end
  end

  // Source edge selection.
  always_comb begin
    case (cfg.source_select) // [RULE3] [RULE21]
      MODULO_TIMER_SRC_BUS: src_tick = 1'b1;
      MODULO_TIMER_SRC_FIXED: src_tick = ff_s2 & ~ff_prev;
      MODULO_TIMER_SRC_EXT_FALL: src_tick = ~ext_s2 & ext_prev;
      MODULO_TIMER_SRC_EXT_RISE: src_tick = ext_s2 & ~ext_prev;
      default: src_tick = 1'b0;
    endcase
  end

  // Counting stops for halt, stop mode and debug; wait mode does not stop it.
  assign run = ~halt & ~stop_mode_i & ~debug_halt_i; // [RULE6] [RULE7] [RULE9] [RULE12]
  assign tick = run & src_tick & ((presc & div_mask(cfg.prescale_select))
    == div_mask(cfg.prescale_select)); // [RULE4]
  assign limit = (modv == 8'h00) ? 8'hFF : modv; // [RULE23]
  assign wrap = tick & (cnt == limit); // [RULE1]

  // Prescaler counts selected source edges.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc <= 8'h00;
    end else if (clr_evt) begin
      presc <= 8'h00; // [RULE13]
    end else if (run & src_tick) begin
      presc <= presc + 8'h01;
    end
  end

  // Main counter, cleared by timer reset before any resume.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= MODULO_TIMER_RST_COUNT;
    end else if (clr_evt) begin
      cnt <= 8'h00; // [RULE5] [RULE13]
    end else if (wrap) begin
      cnt <= 8'h00; // [RULE1]
    end else if (tick) begin
      cnt <= cnt + 8'h01; // [RULE11]
    end
  end

  // Software clear needs a status read with the flag set, then a zero write.
  assign flag_swclr = wr_status & armed & ~writedata_i[MODULO_TIMER_BIT_FLAG];

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed <= 1'b0;
    end else if (rd_status & flag) begin
      armed <= 1'b1;
    end else if (wr_status | ~flag) begin
      armed <= 1'b0;
    end
  end

  // Overflow flag: a wrap wins over a software clear in the same cycle.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag <= 1'b0;
    end else if (clr_evt) begin
      flag <= 1'b0; // [RULE13]
    end else if (wrap) begin
      flag <= 1'b1; // [RULE19]
    end else if (flag_swclr) begin
      flag <= 1'b0; // [RULE19]
    end
  end

  // Interrupt level; it also serves as the wake request in wait mode.
  assign irq_o = flag & ie; // [RULE24] [RULE2] [RULE7]

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  cnt_range_a: assert property (cnt <= limit || $past(wr_mod)) // [RULE1]
    else $error("count above limit");
  wrap_flag_a: assert property (wrap && !clr_evt |=> flag && cnt == 8'h00) // [RULE19]
    else $error("wrap did not set flag");
  irq_follow_a: assert property ($rose(flag) && ie |-> irq_o) // [RULE24]
    else $error("irq missing on flag");
  halt_hold_a: assert property (halt && !clr_evt |=> cnt == $past(cnt)) // [RULE6]
    else $error("count moved while halted");
  stop_hold_a: assert property (stop_mode_i && !clr_evt |=> cnt == $past(cnt)) // [RULE9]
    else $error("count moved in stop");
  debug_hold_a: assert property (debug_halt_i && !clr_evt |=> $stable(cnt)) // [RULE12]
    else $error("count moved in debug");
  timer_clear_a: assert property (clr_evt |=> cnt == 8'h00 && !flag) // [RULE13]
    else $error("timer reset failed");
  div_one_a: assert property (run && src_tick && cfg.prescale_select == 4'h0
    && !clr_evt && cnt != limit |=> cnt == $past(cnt) + 8'h01) // [RULE4]
    else $error("divide by one missed");
  wait_state_a: assert property (req && !done |=> !waitrequest_o || !req)
    else $error("access not answered");

  ovf_c: cover property (wrap && ie);
  clr_c: cover property (clr_evt && cnt != 8'h00);
  wait_wake_c: cover property (wait_mode_i && $rose(irq_o));
  stop_freeze_c: cover property (stop_mode_i && src_tick);
  flag_swclr_c: cover property (flag_swclr);

  // Wait mode leaves a running counter counting.
  wait_run_a: assert property ( // [RULE7]
    wait_mode_i && run && src_tick && cfg.prescale_select == 4'h0 && !clr_evt && cnt != limit
    |=> cnt == $past(cnt) + 8'h01)
    else $error("count stalled in wait");
  // Stop mode freezes the prescaler too, so no partial division leaks out.
  stop_presc_a: assert property ( // [RULE9]
    stop_mode_i && !clr_evt
    |=> $stable(presc))
    else $error("prescaler moved in stop");
  // Debug halt freezes the prescaler too.
  debug_presc_a: assert property ( // [RULE12]
    debug_halt_i && !clr_evt
    |=> $stable(presc))
    else $error("prescaler moved in debug");
  // No overflow can appear in stop, so the timer never wakes the core from it.
  stop_nowake_a: assert property ( // [RULE9]
    stop_mode_i && !flag
    |=> !flag)
    else $error("flag set in stop");
  // The count still holds its value in the first cycle after stop ends.
  stop_resume_a: assert property ( // [RULE11]
    $fell(stop_mode_i) && !$past(clr_evt)
    |-> cnt == $past(cnt))
    else $error("count lost over stop");
  // A clock configuration write never touches the count.
  cfg_keep_a: assert property ( // [RULE21]
    wr_clkcfg && !tick
    |=> $stable(cnt))
    else $error("config write moved count");
  // A timer reset also clears the prescaler.
  presc_clear_a: assert property ( // [RULE13]
    clr_evt
    |=> presc == 8'h00)
    else $error("prescaler not cleared");
  // A modulo write stores the written byte.
  mod_store_a: assert property ( // [RULE13]
    wr_mod
    |=> modv == $past(writedata_i[7:0]))
    else $error("modulo not stored");
  // A status write sets the halt control as written.
  halt_store_a: assert property ( // [RULE6]
    wr_status
    |=> halt == $past(writedata_i[MODULO_TIMER_BIT_HALT]))
    else $error("halt not stored");
  // A status write sets the interrupt enable as written.
  ie_store_a: assert property ( // [RULE2]
    wr_status
    |=> ie == $past(writedata_i[MODULO_TIMER_BIT_IE]))
    else $error("enable not stored");
  // The armed zero write clears the flag when no wrap coincides.
  flag_swclr_a: assert property ( // [RULE19]
    flag_swclr && !wrap
    |=> !flag)
    else $error("flag not cleared");
  // The flag holds until one of its clearing events.
  flag_hold_a: assert property ( // [RULE19]
    flag && !clr_evt && !flag_swclr
    |=> flag)
    else $error("flag dropped");
  // Only a wrap can set the flag.
  flag_cause_a: assert property ( // [RULE19]
    !flag && !wrap
    |=> !flag)
    else $error("flag set without wrap");
  // The bus clock source offers an edge on every cycle.
  src_bus_a: assert property ( // [RULE3]
    cfg.source_select == MODULO_TIMER_SRC_BUS
    |-> src_tick)
    else $error("bus source idle");
  // A rising pin edge is used only after two synchroniser stages.
  pin_sync_a: assert property ( // [RULE14]
    cfg.source_select == MODULO_TIMER_SRC_EXT_RISE && src_tick
    |-> $past(ext_count_pin_i, 2) && !$past(ext_count_pin_i, 3))
    else $error("pin edge not synchronised");
  // Undefined prescale codes divide by 256.
  ps_top_a: assert property ( // [RULE22]
    cfg.prescale_select > MODULO_TIMER_PS_MAX
    |-> div_mask(cfg.prescale_select) == 8'hFF)
    else $error("bad prescale default");
  // Writes to the count register are ignored.
  count_ro_a: assert property ( // [RULE16]
    acc_wr && address_i == MODULO_TIMER_OFS_COUNT && !tick
    |=> $stable(cnt))
    else $error("count was written");
  // A count read returns the count seen in the request cycle.
  count_read_a: assert property ( // [RULE16]
    read_i && !done && address_i == MODULO_TIMER_OFS_COUNT
    |=> readdata_o == {24'h00_0000, $past(cnt)})
    else $error("count read wrong");
  // The interrupt stays low while it is disabled.
  irq_mask_a: assert property ( // [RULE24]
    !ie
    |-> !irq_o)
    else $error("irq while disabled");

endmodule // modulo_timer_top
`default_nettype wire

/* modulo_timer_pkg.sv */
package modulo_timer_pkg;
  // Register byte offsets, one aligned word each.
  localparam logic [3:0] MODULO_TIMER_OFS_STATUS = 4'h0;
  localparam logic [3:0] MODULO_TIMER_OFS_CLKCFG = 4'h4;
  localparam logic [3:0] MODULO_TIMER_OFS_COUNT = 4'h8;
  localparam logic [3:0] MODULO_TIMER_OFS_MODULO = 4'hC;
  // Status and control bit positions.
  localparam int MODULO_TIMER_BIT_FLAG = 7;
  localparam int MODULO_TIMER_BIT_IE = 6;
  localparam int MODULO_TIMER_BIT_CLR = 5;
  localparam int MODULO_TIMER_BIT_HALT = 4;
  // Reset values.
  localparam logic MODULO_TIMER_RST_HALT = 1'b1;
  localparam logic MODULO_TIMER_RST_IE = 1'b0;
  localparam logic [7:0] MODULO_TIMER_RST_COUNT = 8'h00;
  localparam logic [7:0] MODULO_TIMER_RST_MODULO = 8'h00;
  // Largest defined prescale code, divide by 256.
  localparam logic [3:0] MODULO_TIMER_PS_MAX = 4'h8;
  // Prescaler source encodings.
  typedef enum logic [1:0] {
    MODULO_TIMER_SRC_BUS = 2'b00,
    MODULO_TIMER_SRC_FIXED = 2'b01,
    MODULO_TIMER_SRC_EXT_FALL = 2'b10,
    MODULO_TIMER_SRC_EXT_RISE = 2'b11
  } modulo_timer_src_t;
  // Clock configuration register layout.
  typedef struct packed {
    logic [1:0] unused;
    modulo_timer_src_t source_select;
    logic [3:0] prescale_select;
  } modulo_timer_clkcfg_t;
  localparam modulo_timer_clkcfg_t MODULO_TIMER_RST_CLKCFG = '{2'b00, MODULO_TIMER_SRC_BUS, 4'h0};
endpackage

/* modulo_timer_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Far-side model of the count pin and the fixed-frequency clock source.
module modulo_timer_pin_model (
  // Bus clock that paces every edge.
  input wire logic mclk_i,
  // Count pin and fixed clock.
  output logic ext_count_pin_o,
  output logic divided_ref_clock_o
);
  // Both lines rest low between bursts, so no stray edge reaches the timer.
  initial begin
    ext_count_pin_o = 1'b0;
    divided_ref_clock_o = 1'b0;
  end
  // Sends n pulses, four clocks high and four low: an eighth of the bus rate.
  task automatic pulse(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk_i);
      ext_count_pin_o <= ~ext_count_pin_o;
      divided_ref_clock_o <= ~divided_ref_clock_o;
      repeat (3) @(posedge mclk_i);
    end
  endtask
endmodule // modulo_timer_pin_model
`default_nettype wire

/* modulo_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the modulo timer.
module testbench;
  import modulo_timer_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [2:0] mode = 3'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic ext_pin;
  logic ref_clk;
  int fail_count = 0;
  int cmp_count = 0;
  // Design and far-side model; mode bits are wait, stop and debug.
  modulo_timer_top modulo_timer_top_i (.mclk_i(mclk), .resetn_i(resetn), .address_i(address),
    .byteenable_i(byteenable), .read_i(read), .write_i(write), .writedata_i(writedata),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .ext_count_pin_i(ext_pin),
    .divided_ref_clock_i(ref_clk), .wait_mode_i(mode[0]), .stop_mode_i(mode[1]),
    .debug_halt_i(mode[2]), .irq_o(irq));
  modulo_timer_pin_model modulo_timer_pin_model_i (.mclk_i(mclk), .ext_count_pin_o(ext_pin),
    .divided_ref_clock_o(ref_clk));
  // Free-running bus clock.
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low.
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 8'h0, q);
    check(q, exp);
  endtask
  // Reset values, reserved bits, read-only count and an unmapped address.
  task automatic t_regs();
    rdc(MODULO_TIMER_OFS_STATUS, 32'h10);
    rdc(MODULO_TIMER_OFS_CLKCFG, 32'h0);
    rdc(MODULO_TIMER_OFS_COUNT, 32'h0);
    rdc(MODULO_TIMER_OFS_MODULO, 32'h0);
    rdc(4'h2, 32'h0);
    wr(MODULO_TIMER_OFS_CLKCFG, 8'hFF);
    rdc(MODULO_TIMER_OFS_CLKCFG, 32'h3F);
    wr(MODULO_TIMER_OFS_COUNT, 8'h55);
    rdc(MODULO_TIMER_OFS_COUNT, 32'h0);
    wr(MODULO_TIMER_OFS_MODULO, 8'hA5);
    rdc(MODULO_TIMER_OFS_MODULO, 32'hA5);
    byteenable <= 4'hE;
    wr(MODULO_TIMER_OFS_MODULO, 8'h11);
    byteenable <= 4'hF;
    rdc(MODULO_TIMER_OFS_MODULO, 32'hA5);
  endtask
  // Every prescaler source, then a source change that keeps the count.
  task automatic t_sources();
    logic [31:0] q;
    for (int s = 1; s < 4; s++) begin
      wr(MODULO_TIMER_OFS_CLKCFG, {2'b00, 2'(s), 4'h0});
      wr(MODULO_TIMER_OFS_STATUS, 8'h20);
      modulo_timer_pin_model_i.pulse(5);
      rdc(MODULO_TIMER_OFS_COUNT, 32'h5);
    end
    wr(MODULO_TIMER_OFS_CLKCFG, 8'h20);
    rdc(MODULO_TIMER_OFS_COUNT, 32'h5);
    wr(MODULO_TIMER_OFS_CLKCFG, 8'h00);
    wr(MODULO_TIMER_OFS_STATUS, 8'h20);
    wr(MODULO_TIMER_OFS_STATUS, 8'h10);
    access(1'b0, MODULO_TIMER_OFS_COUNT, 8'h0, q);
    check(32'(q > 0 && q < 8), 32'h1);
    rdc(MODULO_TIMER_OFS_COUNT, q);
  endtask
  // All nine dividers plus two undefined codes, eight pin pulses each.
  task automatic t_prescale();
    for (int p = 0; p < 11; p++) begin
      wr(MODULO_TIMER_OFS_CLKCFG, {4'h3, (p == 10) ? 4'hF : 4'(p)});
      wr(MODULO_TIMER_OFS_STATUS, 8'h20);
      modulo_timer_pin_model_i.pulse(8);
      rdc(MODULO_TIMER_OFS_COUNT, 32'h8 >> ((p > 8) ? 8 : p));
    end
  endtask
  // Wait keeps counting (left running with the interrupt disabled); stop and debug freeze.
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      wr(MODULO_TIMER_OFS_CLKCFG, 8'h30);
      wr(MODULO_TIMER_OFS_STATUS, 8'h20);
      modulo_timer_pin_model_i.pulse(2);
      mode <= 3'(1 << m);
      modulo_timer_pin_model_i.pulse(3);
      mode <= 3'h0;
      modulo_timer_pin_model_i.pulse(1);
      rdc(MODULO_TIMER_OFS_COUNT, (m == 0) ? 32'h6 : 32'h3);
    end
  endtask
  // Modulo wrap, flag and interrupt, flag clearing, free run.
  task automatic t_wrap();
    wr(MODULO_TIMER_OFS_MODULO, 8'h03);
    wr(MODULO_TIMER_OFS_STATUS, 8'h60);
    modulo_timer_pin_model_i.pulse(4);
    rdc(MODULO_TIMER_OFS_STATUS, 32'hC0);
    check(32'(irq), 32'h1);
    rdc(MODULO_TIMER_OFS_COUNT, 32'h0);
    wr(MODULO_TIMER_OFS_STATUS, 8'h40);
    rdc(MODULO_TIMER_OFS_STATUS, 32'h40);
    check(32'(irq), 32'h0);
    modulo_timer_pin_model_i.pulse(4);
    wr(MODULO_TIMER_OFS_MODULO, 8'h00);
    rdc(MODULO_TIMER_OFS_STATUS, 32'h40);
    modulo_timer_pin_model_i.pulse(255);
    rdc(MODULO_TIMER_OFS_COUNT, 32'hFF);
    modulo_timer_pin_model_i.pulse(1);
    check(32'(irq), 32'h1);
    wr(MODULO_TIMER_OFS_STATUS, 8'h60);
    rdc(MODULO_TIMER_OFS_STATUS, 32'h40);
    rdc(MODULO_TIMER_OFS_COUNT, 32'h0);
  endtask
  // Leaving stop through reset restores the reset state.
  task automatic t_stop_reset();
    wr(MODULO_TIMER_OFS_MODULO, 8'h07);
    wr(MODULO_TIMER_OFS_STATUS, 8'h40);
    mode <= 3'h2;
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    mode <= 3'h0;
    rdc(MODULO_TIMER_OFS_STATUS, 32'h10);
    rdc(MODULO_TIMER_OFS_MODULO, 32'h0);
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_sources();
    t_prescale();
    t_modes();
    t_wrap();
    t_stop_reset();
    tally_and_finish();
  end
  // Watchdog, far beyond the roughly 3,400 cycles the tests need.
  initial begin
    repeat (50000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
